// file: rtl/cpdc_pkg.sv
// Package with register map, field positions and decoded types for the clock and power-down bank.
package cpdc_pkg;

  // ---------------------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_CLOCK_MODE      = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_POWER_DOWN_CTRL = 5'h02;
  localparam logic [ADDR_W-1:0] ADDR_RX_CH_ONE_PD    = 5'h03;
  localparam logic [ADDR_W-1:0] ADDR_RX_CH_TWO_PD    = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_RX_BIAS_PD      = 5'h05;

  localparam logic [DATA_W-1:0] RST_CLOCK_MODE       = 8'h00;
  localparam logic [DATA_W-1:0] RST_POWER_DOWN_CTRL  = 8'h00;
  localparam logic [DATA_W-1:0] RST_RX_CH_PD         = 8'h00;
  localparam logic [DATA_W-1:0] RST_RX_BIAS_PD       = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_UNMAPPED       = 8'h00;

  localparam int unsigned NUM_RX_CH = 2;

  // ---------------------------------------------------------------------------
  // Clock mode register fields
  // ---------------------------------------------------------------------------
  localparam int unsigned CM_SEL_HI      = 7;
  localparam int unsigned CM_SEL_LO      = 5;
  localparam int unsigned CM_PIN2_CLK_EN = 2;
  localparam int unsigned CM_PIN3_INV    = 1;

  localparam logic [2:0] CM_STANDARD    = 3'h0;
  localparam logic [2:0] CM_OPT_TWO_WAY = 3'h1;
  localparam logic [2:0] CM_OPT_HD20    = 3'h3;
  localparam logic [2:0] CM_OPT_HD10    = 3'h5;
  localparam logic [2:0] CM_UNUSED_110  = 3'h6;
  localparam logic [2:0] CM_CLONE       = 3'h7;

  // ---------------------------------------------------------------------------
  // Power-down register fields
  // ---------------------------------------------------------------------------
  localparam int unsigned PD_TXA_HI      = 7;
  localparam int unsigned PD_TXA_LO      = 5;
  localparam int unsigned PD_TX_DIGITAL  = 4;
  localparam int unsigned PD_RX_DIGITAL  = 3;
  localparam int unsigned PD_PLL         = 2;
  localparam int unsigned PD_PLL_DISCON  = 1;

  localparam logic [2:0] TXA_PD_CH_ONE   = 3'h4;
  localparam logic [2:0] TXA_PD_CH_TWO   = 3'h2;
  localparam logic [2:0] TXA_PD_BOTH     = 3'h7;

  localparam int unsigned RXC_ANALOG_PD  = 7;
  localparam int unsigned RXC_BIAS_PD    = 6;
  localparam int unsigned RXB_ALL_BIAS   = 7;

  // ---------------------------------------------------------------------------
  // Decoded types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CPDC_TIM_STANDARD,
    CPDC_TIM_OPT_TWO_WAY,
    CPDC_TIM_OPT_HD20,
    CPDC_TIM_OPT_HD10,
    CPDC_TIM_CLONE
  } cpdc_timing_type;

  typedef struct packed {
    logic ch_one_out_pd;
    logic ch_two_out_pd;
    logic support_pd;
    logic digital_clk_en;
    logic hold_outputs;
  } cpdc_tx_pd_type;

  typedef struct packed {
    logic pll_pd;
    logic pll_bypass;
    logic pll_out_connected;
  } cpdc_pll_type;

  typedef struct packed {
    logic analog_pd;
    logic digital_pd;
    logic bias_net_pd;
  } cpdc_rx_ch_type;

endpackage : cpdc_pkg

// file: rtl/cpdc_ctrl.sv
// Clock-option and power-down control register bank with decoded control outputs.
`timescale 1ns/10ps
// Behaviour
// RULE1: Clocking selector code 110 is unused; code 111 selects clone mode timing.
// RULE2: Second-pin clock enable drives that pin as clock, inverted in full-duplex.
// RULE3: Third-pin invert bit inverts the output clock driven on the third pin.
// RULE4: Tx analog field: 100 kills output one, 010 output two, 111 both plus support.
// RULE5: Tx digital power-down stops Tx digital clocks; outputs hold last values.
// RULE6: Rx digital power-down bit powers down the receive digital section.
// RULE7: PLL power-down bit powers the multiplier down and bypasses the PLL.
// RULE8: With PLL bypassed, the system supplies the fastest on-chip clock frequency.
// RULE9: PLL disconnect removes PLL output from clock path; PLL keeps locking.
// RULE10: Per-channel analog power-down kills channel analog and digital; band gap stays.
// RULE11: Per-channel bias power-down removes the input common-mode bias network.
// RULE12: Rx analog bias power-down kills all Rx bias circuits and reference buffer.
// RULE13: Clocking selector resets to 000, standard clocking.
// RULE14: Every control bit holds and reads back as written until rewrite or reset.
module cpdc_ctrl
  import cpdc_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_arst_n,
  // Register port from the serial control port decoder
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [ADDR_W-1:0]     i_reg_addr,
  input  wire logic [DATA_W-1:0]     i_reg_wdata,
  output logic      [DATA_W-1:0]     o_reg_rdata,
  // Interface clock and data mode
  input  wire logic                  i_iface_clk,
  input  wire logic                  i_two_way_simultaneous_operation,
  output cpdc_timing_type            o_timing_mode,
  output logic                       o_clk_mode_unused,
  // Flexible port clock pins
  output logic                       o_second_flex_port_pin_o,
  output logic                       o_second_flex_port_pin_oe,
  output logic                       o_third_flex_port_pin_o,
  // Transmit power control
  output cpdc_tx_pd_type             o_tx_pd,
  // Clock path control
  output cpdc_pll_type               o_pll,
  // Receive power control
  output cpdc_rx_ch_type [NUM_RX_CH-1:0] o_rx_ch,
  output logic                       o_rx_digital_pd,
  output logic                       o_rx_all_bias_pd,
  output logic                       o_rx_diff_ref_buf_pd,
  output logic                       o_rx_bandgap_en
);

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] clk_mode_r;
  logic [DATA_W-1:0] clk_mode_nxt;
  logic [DATA_W-1:0] pd_ctrl_r;
  logic [DATA_W-1:0] pd_ctrl_nxt;
  logic [DATA_W-1:0] rx_bias_r;
  logic [DATA_W-1:0] rx_bias_nxt;
  logic [DATA_W-1:0] rx_ch_r   [NUM_RX_CH];
  logic [DATA_W-1:0] rx_ch_nxt [NUM_RX_CH];
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // Writes land only on a matching address; other bits keep their value.
  always_comb begin
    clk_mode_nxt = clk_mode_r;
    pd_ctrl_nxt  = pd_ctrl_r;
    rx_bias_nxt  = rx_bias_r;
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_CLOCK_MODE:      clk_mode_nxt = i_reg_wdata; // see RULE14
        ADDR_POWER_DOWN_CTRL: pd_ctrl_nxt  = i_reg_wdata; // see RULE14
        ADDR_RX_BIAS_PD:      rx_bias_nxt  = i_reg_wdata; // see RULE14
        default: begin
          clk_mode_nxt = clk_mode_r;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_mode_r <= RST_CLOCK_MODE; // see RULE13
      pd_ctrl_r  <= RST_POWER_DOWN_CTRL;
      rx_bias_r  <= RST_RX_BIAS_PD;
    end else begin
      clk_mode_r <= clk_mode_nxt;
      pd_ctrl_r  <= pd_ctrl_nxt;
      rx_bias_r  <= rx_bias_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Receive channel registers, one per channel
  // ---------------------------------------------------------------------------
  generate
    for (genvar ch = 0; ch < NUM_RX_CH; ch++) begin : g_rx_ch
      localparam logic [ADDR_W-1:0] CH_ADDR = ADDR_RX_CH_ONE_PD + ADDR_W'(ch);

      always_comb begin
        rx_ch_nxt[ch] = rx_ch_r[ch];
        if (i_reg_wr && (i_reg_addr == CH_ADDR)) begin
          rx_ch_nxt[ch] = i_reg_wdata; // see RULE14
        end
      end

      always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          rx_ch_r[ch] <= RST_RX_CH_PD;
        end else begin
          rx_ch_r[ch] <= rx_ch_nxt[ch];
        end
      end

      // The band gap is not part of the channel power-down, so recovery stays quick.
      assign o_rx_ch[ch].analog_pd   = rx_ch_r[ch][RXC_ANALOG_PD]; // see RULE10
      assign o_rx_ch[ch].digital_pd  = rx_ch_r[ch][RXC_ANALOG_PD]; // see RULE10
      assign o_rx_ch[ch].bias_net_pd = rx_ch_r[ch][RXC_BIAS_PD];   // see RULE11
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Read-back
  // ---------------------------------------------------------------------------
  // Read data is registered: it appears the cycle after the read strobe and holds.
  always_comb begin
    rdata_nxt = rdata_r;
    if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_CLOCK_MODE:      rdata_nxt = clk_mode_r; // see RULE14
        ADDR_POWER_DOWN_CTRL: rdata_nxt = pd_ctrl_r;
        ADDR_RX_CH_ONE_PD:    rdata_nxt = rx_ch_r[0];
        ADDR_RX_CH_TWO_PD:    rdata_nxt = rx_ch_r[1];
        ADDR_RX_BIAS_PD:      rdata_nxt = rx_bias_r;
        default: begin
          rdata_nxt = RDATA_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= RDATA_UNMAPPED;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;

  // ---------------------------------------------------------------------------
  // Interface clocking selector
  // ---------------------------------------------------------------------------
  logic [2:0] clk_sel;

  assign clk_sel = clk_mode_r[CM_SEL_HI:CM_SEL_LO];

  // Unused codes fall back to standard timing so the port never runs undefined.
  always_comb begin
    o_clk_mode_unused = 1'b0;
    case (clk_sel)
      CM_STANDARD:    o_timing_mode = CPDC_TIM_STANDARD;    // see RULE13
      CM_OPT_TWO_WAY: o_timing_mode = CPDC_TIM_OPT_TWO_WAY;
      CM_OPT_HD20:    o_timing_mode = CPDC_TIM_OPT_HD20;
      CM_OPT_HD10:    o_timing_mode = CPDC_TIM_OPT_HD10;
      CM_CLONE:       o_timing_mode = CPDC_TIM_CLONE;       // see RULE1
      CM_UNUSED_110: begin
        o_timing_mode     = CPDC_TIM_STANDARD;        // see RULE1
        o_clk_mode_unused = 1'b1;
      end
      default: begin
        o_timing_mode     = CPDC_TIM_STANDARD;
        o_clk_mode_unused = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Flexible port output clocks
  // ---------------------------------------------------------------------------
  // These pass the interface clock straight through; a flop would halve it.
  assign o_second_flex_port_pin_oe = clk_mode_r[CM_PIN2_CLK_EN]; // see RULE2
  assign o_second_flex_port_pin_o  = clk_mode_r[CM_PIN2_CLK_EN]
                                   & (i_iface_clk ^ i_two_way_simultaneous_operation); // see RULE2
  assign o_third_flex_port_pin_o   = i_iface_clk ^ clk_mode_r[CM_PIN3_INV]; // see RULE3

  // ---------------------------------------------------------------------------
  // Transmit power-down decode
  // ---------------------------------------------------------------------------
  logic [2:0] tx_an_sel;

  assign tx_an_sel = pd_ctrl_r[PD_TXA_HI:PD_TXA_LO];

  // Codes outside the three listed options leave both outputs running.
  always_comb begin
    o_tx_pd = '0;
    case (tx_an_sel)
      TXA_PD_CH_ONE: o_tx_pd.ch_one_out_pd = 1'b1; // see RULE4
      TXA_PD_CH_TWO: o_tx_pd.ch_two_out_pd = 1'b1; // see RULE4
      TXA_PD_BOTH: begin
        o_tx_pd.ch_one_out_pd = 1'b1; // see RULE4
        o_tx_pd.ch_two_out_pd = 1'b1;
        o_tx_pd.support_pd    = 1'b1;
      end
      default: begin
        o_tx_pd.support_pd = 1'b0;
      end
    endcase
    o_tx_pd.digital_clk_en = ~pd_ctrl_r[PD_TX_DIGITAL]; // see RULE5
    o_tx_pd.hold_outputs   = pd_ctrl_r[PD_TX_DIGITAL];  // see RULE5
  end

  // ---------------------------------------------------------------------------
  // Receive digital, PLL and bias controls
  // ---------------------------------------------------------------------------
  assign o_rx_digital_pd = pd_ctrl_r[PD_RX_DIGITAL]; // see RULE6

  // Disconnect does not reach the PLL power control, so lock is kept meanwhile.
  // With the PLL bypassed, the reference pin must carry the fastest internal rate.
  assign o_pll.pll_pd            = pd_ctrl_r[PD_PLL]; // see RULE7 RULE9
  assign o_pll.pll_bypass        = pd_ctrl_r[PD_PLL]; // see RULE7 RULE8
  assign o_pll.pll_out_connected = ~pd_ctrl_r[PD_PLL] & ~pd_ctrl_r[PD_PLL_DISCON]; // see RULE9

  assign o_rx_all_bias_pd     = rx_bias_r[RXB_ALL_BIAS]; // see RULE12
  assign o_rx_diff_ref_buf_pd = rx_bias_r[RXB_ALL_BIAS]; // see RULE12
  assign o_rx_bandgap_en      = 1'b1;                    // see RULE10

endmodule // cpdc_ctrl

// file: verif/cpdc_ctrl_chk.sv
// Port-level assertions for the clock and power-down control bank.
`timescale 1ns/10ps
module cpdc_ctrl_chk
  import cpdc_pkg::*;
(
  // Clock, reset and register port
  input wire logic              i_sys_clk, i_arst_n, i_reg_wr, i_reg_rd,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata, o_reg_rdata,
  // Clock pins and decoded controls
  input wire logic              i_iface_clk, i_two_way_simultaneous_operation,
  input wire logic              o_second_flex_port_pin_o, o_second_flex_port_pin_oe,
  input wire logic              o_third_flex_port_pin_o, o_clk_mode_unused, o_rx_digital_pd,
  input wire logic              o_rx_all_bias_pd, o_rx_diff_ref_buf_pd, o_rx_bandgap_en,
  input cpdc_timing_type        o_timing_mode,
  input cpdc_tx_pd_type         o_tx_pd,
  input cpdc_pll_type           o_pll,
  input cpdc_rx_ch_type [NUM_RX_CH-1:0] o_rx_ch
);
  // --------------------
  // Assertions
  // --------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // Decodes follow the registers, so a write shows one cycle later.
  sequence s_wr_mode; i_reg_wr && i_reg_addr == ADDR_CLOCK_MODE; endsequence
  sequence s_wr_pd; i_reg_wr && i_reg_addr == ADDR_POWER_DOWN_CTRL; endsequence
  sequence s_wr_ch_one; i_reg_wr && i_reg_addr == ADDR_RX_CH_ONE_PD; endsequence
  sequence s_wr_ch_two; i_reg_wr && i_reg_addr == ADDR_RX_CH_TWO_PD; endsequence
  a_rx_ch_one: assert property (s_wr_ch_one |=>
    o_rx_ch[0] == {{2{$past(i_reg_wdata[RXC_ANALOG_PD])}}, $past(i_reg_wdata[RXC_BIAS_PD])}
    && o_rx_ch[1] == $past(o_rx_ch[1])) else $error("channel one power-down wrong");
  a_rx_ch_two: assert property (s_wr_ch_two |=>
    o_rx_ch[1] == {{2{$past(i_reg_wdata[RXC_ANALOG_PD])}}, $past(i_reg_wdata[RXC_BIAS_PD])}
    && o_rx_ch[0] == $past(o_rx_ch[0])) else $error("channel two power-down wrong");
  a_reset_standard: assert property ($rose(i_arst_n)
    |-> o_timing_mode == CPDC_TIM_STANDARD) else $error("mode not standard after reset");
  a_clone_code: assert property (s_wr_mode ##0 i_reg_wdata[7:5] == CM_CLONE
    |=> o_timing_mode == CPDC_TIM_CLONE && !o_clk_mode_unused) else $error("clone not decoded");
  a_pin2_clock: assert property (o_second_flex_port_pin_o == (o_second_flex_port_pin_oe
    && (i_iface_clk ^ i_two_way_simultaneous_operation))) else $error("pin two clock wrong");
  a_pin3_invert: assert property (s_wr_mode |=> o_third_flex_port_pin_o
    == (i_iface_clk ^ $past(i_reg_wdata[CM_PIN3_INV]))) else $error("pin three polarity wrong");
  a_tx_both: assert property (s_wr_pd ##0 i_reg_wdata[7:5] == TXA_PD_BOTH
    |=> o_tx_pd[4:2] == 3'h7) else $error("tx outputs not all off");
  a_digital_stop: assert property (s_wr_pd |=> o_tx_pd.digital_clk_en
    == !$past(i_reg_wdata[PD_TX_DIGITAL]) && o_rx_digital_pd == $past(i_reg_wdata[PD_RX_DIGITAL]))
    else $error("digital power-down wrong");
  a_pll_path: assert property (s_wr_pd |=> o_pll.pll_pd == $past(i_reg_wdata[PD_PLL])
    && o_pll.pll_out_connected == ($past(i_reg_wdata[2:1]) == 2'h0)) else $error("pll path wrong");
  a_bias_all: assert property (i_reg_rd && i_reg_addr == ADDR_RX_BIAS_PD
    |=> o_reg_rdata[RXB_ALL_BIAS] == $past(o_rx_all_bias_pd)
    && o_rx_diff_ref_buf_pd == o_rx_all_bias_pd && o_rx_bandgap_en) else $error("bias wrong");
endmodule // cpdc_ctrl_chk

bind cpdc_ctrl cpdc_ctrl_chk u_cpdc_ctrl_chk (.*);

// file: verif/tb.sv
// Self-checking testbench for the clock and power-down control bank.
`timescale 1ns/10ps
module tb
  import cpdc_pkg::*;
;
  // --------------------
  // Signals and tasks
  // --------------------
  logic              i_sys_clk = 1'h0, i_arst_n = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0;
  logic              i_iface_clk = 1'h0, i_two_way_simultaneous_operation = 1'h0;
  logic [ADDR_W-1:0] i_reg_addr = 5'h00;
  logic [DATA_W-1:0] i_reg_wdata = 8'h00, o_reg_rdata;
  logic              o_clk_mode_unused, o_rx_digital_pd, o_rx_bandgap_en, o_third_flex_port_pin_o;
  logic              o_second_flex_port_pin_o, o_second_flex_port_pin_oe;
  logic              o_rx_all_bias_pd, o_rx_diff_ref_buf_pd;
  cpdc_timing_type   o_timing_mode;
  cpdc_tx_pd_type    o_tx_pd;
  cpdc_pll_type      o_pll;
  cpdc_rx_ch_type [NUM_RX_CH-1:0] o_rx_ch;
  int                errors = 0, tests_run = 0;
  cpdc_timing_type   tm_tab [8] = '{CPDC_TIM_STANDARD, CPDC_TIM_OPT_TWO_WAY,
    CPDC_TIM_STANDARD, CPDC_TIM_OPT_HD20, CPDC_TIM_STANDARD, CPDC_TIM_OPT_HD10, CPDC_TIM_STANDARD,
    CPDC_TIM_CLONE};
  cpdc_ctrl u_cpdc_ctrl (.*);
  // The bench clock stands for the reference pin at the full on-chip rate, as a bypassed PLL needs.
  always #10 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) i_iface_clk <= ~i_iface_clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Accesses end at a falling edge so that decoded outputs have settled.
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    i_reg_wr <= 1'h1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'h0;
    @(negedge i_sys_clk);
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge i_sys_clk);
    i_reg_rd <= 1'h1;
    i_reg_addr <= a;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'h0;
    @(negedge i_sys_clk);
    chk("rdata", e, o_reg_rdata);
  endtask
  task automatic t_reset;
    for (int a = 1; a < 6; a++) rd_chk(a[ADDR_W-1:0], 8'h00);
    chk("pd reset", 8'h11, {o_tx_pd, o_pll});
    chk("pins reset", {CPDC_TIM_STANDARD, 4'h0, i_iface_clk},
      {o_timing_mode, o_clk_mode_unused, o_second_flex_port_pin_oe, o_second_flex_port_pin_o,
      1'h0, o_third_flex_port_pin_o});
  endtask
  // A reset in mid-run must bring every register back to its default.
  task automatic t_reset_again;
    @(posedge i_sys_clk);
    i_arst_n <= 1'h0;
    repeat (2) @(posedge i_sys_clk);
    i_arst_n <= 1'h1;
    t_reset();
  endtask
  task automatic t_clock;
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      @(posedge i_sys_clk);
      i_two_way_simultaneous_operation <= i[0];
      wr_reg(ADDR_CLOCK_MODE, {i[2:0], 5'h06});
      e = {tm_tab[i], i == 2 || i == 4 || i == 6, 1'h1, i_iface_clk ^ i[0], ~i_iface_clk, 1'h0};
      chk("mode", e, {o_timing_mode, o_clk_mode_unused, o_second_flex_port_pin_oe,
        o_second_flex_port_pin_o, o_third_flex_port_pin_o, 1'h0});
    end
  endtask
  task automatic t_power;
    logic [7:0] d;
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      d = {i[2:0], i[0], i[1], i[2], ~i[0], 1'h0};
      wr_reg(ADDR_POWER_DOWN_CTRL, d);
      e = {3'h0, i == 4 || i == 7, i == 2 || i == 7, i == 7, ~d[4], d[4]};
      chk("tx", e, {3'h0, o_tx_pd});
      e = {4'h0, d[2], d[2], ~d[2] & ~d[1], d[3]};
      chk("pll", e, {4'h0, o_pll, o_rx_digital_pd});
      rd_chk(ADDR_POWER_DOWN_CTRL, d);
    end
  endtask
  task automatic t_rx;
    for (int c = 0; c < 2; c++)
      for (int v = 0; v < 4; v++) begin
        wr_reg(ADDR_RX_CH_ONE_PD + c[ADDR_W-1:0], {v[1:0], 6'h15});
        chk("rx ch", {5'h00, v[1], v[1], v[0]}, {5'h00, o_rx_ch[c]});
        rd_chk(ADDR_RX_CH_ONE_PD + c[ADDR_W-1:0], {v[1:0], 6'h15});
      end
    chk("rx ch kept", 8'h07, {5'h00, o_rx_ch[0]});
    wr_reg(ADDR_RX_BIAS_PD, 8'h80);
    chk("bias", 8'h07, {5'h00, o_rx_all_bias_pd,
      o_rx_diff_ref_buf_pd, o_rx_bandgap_en});
  endtask
  // A write and a read at one edge must return the value from before the write.
  task automatic t_edge;
    wr_reg(5'h1f, 8'hff);
    rd_chk(5'h1f, RDATA_UNMAPPED);
    @(posedge i_sys_clk);
    i_reg_wr <= 1'h1;
    i_reg_rd <= 1'h1;
    i_reg_addr <= ADDR_RX_BIAS_PD;
    i_reg_wdata <= 8'h3c;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'h0;
    i_reg_rd <= 1'h0;
    @(negedge i_sys_clk);
    chk("rdata old", 8'h80, o_reg_rdata);
    rd_chk(ADDR_RX_BIAS_PD, 8'h3c);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_arst_n <= 1'h1;
    t_reset();
    t_clock();
    t_power();
    t_rx();
    t_edge();
    t_reset_again();
    wrap_up();
  end
endmodule // tb
